// [core/fwec_pkg.sv]
package fwec_pkg;
   // ==========================================
   // Register offsets
   localparam logic [7:0] ADDR_PROGRAM_TIMING = 8'hab;
   localparam logic [7:0] ADDR_WORD_ADDRESS_LOW = 8'hac;
   localparam logic [7:0] ADDR_WORD_ADDRESS_HIGH = 8'had;
   localparam logic [7:0] ADDR_PROGRAM_CONTROL = 8'hae;
   localparam logic [7:0] ADDR_PROGRAM_DATA = 8'haf;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hb0;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hb1;

   // ==========================================
   // Reset values and field positions
   localparam logic [5:0] RST_TIMING = 6'h2a;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam int CTL_BUSY = 7;
   localparam int CTL_PENDING = 6;
   localparam int CTL_SPARE5 = 5;
   localparam int CTL_CONT_READ = 4;
   localparam int CTL_SPARE3 = 3;
   localparam int CTL_SPARE2 = 2;
   localparam int CTL_WRITE = 1;
   localparam int CTL_ERASE = 0;
   localparam int IRQ_WRITE_DONE = 0;
   localparam int IRQ_ERASE_DONE = 1;
   localparam int IRQ_BITS = 2;

   // ==========================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int ERASE_TIME_MS = 20;
   localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
   // Word program clock cycles per step of the timing field (length is timing * 4 + 1 cycles)
   localparam int WRITE_UNITS = 4;
   localparam int PAGE_BYTES = 2048;

   typedef enum logic [1:0] {FWEC_IDLE, FWEC_ERASE, FWEC_WRITE} fwec_state_t;
endpackage : fwec_pkg

// [core/fwec_if.sv]
`timescale 1ns/100ps
// Link between sequencer and its timing generator
interface fwec_tgen_if;
   logic start;
   logic is_erase;
   logic [5:0] timing;
   logic [31:0] erase_cycles;
   logic done;
   modport seq (output start, output is_erase, output timing, output erase_cycles, input done);
   modport gen (input start, input is_erase, input timing, input erase_cycles, output done);
endinterface : fwec_tgen_if

// [core/fwec_timing_gen.sv]
`timescale 1ns/100ps
module fwec_timing_gen
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Sequencer side
   fwec_tgen_if.gen tg
);
   typedef struct packed
   {
      logic run;
      logic done;
      logic [31:0] count;
   } fwec_tg_t;

   fwec_tg_t r;
   fwec_tg_t next_r;

   // ==========================================
   // Count down; write length scales with the timing field
   always_comb
   begin
      next_r = r;
      next_r.done = 1'b0;
      if (tg.start)
      begin
         next_r.run = 1'b1;
         if (tg.is_erase)
            next_r.count = tg.erase_cycles;
         else
            next_r.count = 32'(tg.timing) * 32'(fwec_pkg::WRITE_UNITS) + 32'h0000_0001;
      end
      else if (r.run)
      begin
         if (r.count <= 32'h0000_0001)
         begin
            next_r.run = 1'b0;
            next_r.done = 1'b1;
         end
         else
            next_r.count = r.count - 32'h0000_0001;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         r <= '0;
      else if (i_ce)
         r <= next_r;
   end

   assign tg.done = r.done;
endmodule : fwec_timing_gen

// [core/fwec_top.sv]
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module fwec_top
#(
   parameter int ERASE_CYCLES = fwec_pkg::ERASE_CYCLES
)
(
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Register port
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Flash array side
   output logic o_array_prog,
   output logic o_array_erase,
   output logic [14:0] o_array_addr,
   output logic [7:0] o_array_wdata,
   output logic o_array_read_en,
   input wire logic i_array_read_req,
   // Events
   output logic o_dma_trigger,
   output logic o_irq
);
   typedef struct packed
   {
      fwec_pkg::fwec_state_t state;
      logic [5:0] timing;
      logic [7:0] addr_low;
      logic [6:0] addr_high;
      logic bit7_high;
      logic [7:0] data;
      logic cont_read;
      logic [2:0] spare;
      logic write_after;
      logic sw_pending;
      logic [7:0] rdata;
      logic prog;
      logic erase;
      logic read_en;
      logic dma;
      logic tg_start;
      logic tg_erase;
      logic [fwec_pkg::IRQ_BITS-1:0] irq_status;
      logic [fwec_pkg::IRQ_BITS-1:0] irq_mask;
      logic irq;
   } fwec_regs_t;

   fwec_regs_t r;
   fwec_regs_t next_r;
   fwec_tgen_if tg ();
   // Decoded strobes and the next interrupt status
   logic busy;
   logic ctl_wr;
   logic sts_wr;
   logic cmd_erase;
   logic cmd_write;
   logic [fwec_pkg::IRQ_BITS-1:0] ev;
   logic [fwec_pkg::IRQ_BITS-1:0] next_status;

   // ==========================================
   // Timing generator
   fwec_timing_gen u_tgen
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .tg(tg)
   );

   // Generator takes a write's length from the timing field at start, an erase's from ERASE_CYCLES
   assign tg.start = r.tg_start;
   assign tg.is_erase = r.tg_erase;
   assign tg.timing = r.timing;
   assign tg.erase_cycles = 32'(ERASE_CYCLES);
   assign busy = (r.state != fwec_pkg::FWEC_IDLE);

   // ==========================================
   // Command and interrupt decode
   // Commands start only from idle; a busy sequencer drops them
   assign ctl_wr = i_wr && (i_addr == fwec_pkg::ADDR_PROGRAM_CONTROL);
   assign sts_wr = i_wr && (i_addr == fwec_pkg::ADDR_IRQ_STATUS);
   assign cmd_erase = ctl_wr && !busy && i_wdata[fwec_pkg::CTL_ERASE];
   assign cmd_write = ctl_wr && !busy && i_wdata[fwec_pkg::CTL_WRITE];

   // Completion events last one cycle, as the generator's done pulse
   always_comb
   begin
      ev = '0;
      ev[fwec_pkg::IRQ_WRITE_DONE] = (r.state == fwec_pkg::FWEC_WRITE) && tg.done;
      ev[fwec_pkg::IRQ_ERASE_DONE] = (r.state == fwec_pkg::FWEC_ERASE) && tg.done;
   end

   // Sticky status per bit; an event beats a write-one clear
   for (genvar i = 0; i < fwec_pkg::IRQ_BITS; i++)
   begin : g_status
      assign next_status[i] = ev[i] | (r.irq_status[i] & !(sts_wr && i_wdata[i]));
   end

   // ==========================================
   // Register file and sequencer
   always_comb
   begin
      next_r = r;
      next_r.tg_start = 1'b0;
      next_r.dma = 1'b0;
      // Read data valid only in the cycle after the strobe, zero otherwise
      next_r.rdata = fwec_pkg::RST_BYTE;
      if (i_rd)
      begin
         case (i_addr)
            fwec_pkg::ADDR_PROGRAM_TIMING:
            begin
               // Unused top bits read as zero
               next_r.rdata = {2'b00, r.timing};
            end
            fwec_pkg::ADDR_WORD_ADDRESS_LOW:
            begin
               next_r.rdata = r.addr_low;
            end
            fwec_pkg::ADDR_WORD_ADDRESS_HIGH:
            begin
               // Unused bit 7 is kept as plain storage
               next_r.rdata = {r.bit7_high, r.addr_high};
            end
            fwec_pkg::ADDR_PROGRAM_CONTROL:
            begin
               // Command bits read as zero
               next_r.rdata = {busy, r.sw_pending, r.spare[2], r.cont_read,
                               r.spare[1:0], 2'b00};
            end
            fwec_pkg::ADDR_PROGRAM_DATA:
            begin
               next_r.rdata = r.data;
            end
            fwec_pkg::ADDR_IRQ_STATUS:
            begin
               next_r.rdata = 8'(r.irq_status);
            end
            fwec_pkg::ADDR_IRQ_MASK:
            begin
               next_r.rdata = 8'(r.irq_mask);
            end
            default:
            begin
               // Unmapped addresses read as zero
               next_r.rdata = fwec_pkg::RST_BYTE;
            end
         endcase
      end
      if (i_wr)
      begin
         case (i_addr)
            fwec_pkg::ADDR_PROGRAM_TIMING:
            begin
               next_r.timing = i_wdata[5:0];
            end
            fwec_pkg::ADDR_WORD_ADDRESS_LOW:
            begin
               next_r.addr_low = i_wdata;
            end
            fwec_pkg::ADDR_WORD_ADDRESS_HIGH:
            begin
               next_r.addr_high = i_wdata[6:0];
               next_r.bit7_high = i_wdata[7];
            end
            fwec_pkg::ADDR_PROGRAM_DATA:
            begin
               // Overwrite while pending is the software's fault
               next_r.data = i_wdata;
            end
            fwec_pkg::ADDR_PROGRAM_CONTROL:
            begin
               // Mode and spare bits are stored even while busy
               next_r.cont_read = i_wdata[fwec_pkg::CTL_CONT_READ];
               next_r.spare = {i_wdata[fwec_pkg::CTL_SPARE5], i_wdata[fwec_pkg::CTL_SPARE3],
                               i_wdata[fwec_pkg::CTL_SPARE2]};
            end
            fwec_pkg::ADDR_IRQ_MASK:
            begin
               next_r.irq_mask = i_wdata[fwec_pkg::IRQ_BITS-1:0];
            end
            default:
            begin
               // Status clears are decoded per bit above; others are ignored
            end
         endcase
      end
      // Erase wins the start when both command bits are set
      if (cmd_erase)
      begin
         next_r.state = fwec_pkg::FWEC_ERASE;
         next_r.write_after = i_wdata[fwec_pkg::CTL_WRITE];
         next_r.sw_pending = i_wdata[fwec_pkg::CTL_WRITE];
         next_r.tg_start = 1'b1;
         next_r.tg_erase = 1'b1;
         next_r.erase = 1'b1;
      end
      else if (cmd_write)
      begin
         next_r.state = fwec_pkg::FWEC_WRITE;
         next_r.sw_pending = 1'b1;
         next_r.tg_start = 1'b1;
         next_r.tg_erase = 1'b0;
         next_r.prog = 1'b1;
      end
      // Sequencer advances on the generator's done pulse
      case (r.state)
         fwec_pkg::FWEC_IDLE:
         begin
            // Waits for a command
         end
         fwec_pkg::FWEC_ERASE:
         begin
            if (tg.done)
            begin
               // Page now reads all ones in the array
               next_r.erase = 1'b0;
               if (r.write_after)
               begin
                  // Word write follows the erase without software help
                  next_r.state = fwec_pkg::FWEC_WRITE;
                  next_r.tg_start = 1'b1;
                  next_r.tg_erase = 1'b0;
                  next_r.prog = 1'b1;
               end
               else
               begin
                  next_r.state = fwec_pkg::FWEC_IDLE;
               end
            end
         end
         fwec_pkg::FWEC_WRITE:
         begin
            if (tg.done)
            begin
               // Word committed: free the data register and tell the DMA
               next_r.state = fwec_pkg::FWEC_IDLE;
               next_r.prog = 1'b0;
               next_r.sw_pending = 1'b0;
               next_r.write_after = 1'b0;
               next_r.dma = 1'b1;
            end
         end
         default:
         begin
            next_r.state = fwec_pkg::FWEC_IDLE;
         end
      endcase
      // Status bits, and the interrupt level from the new values
      next_r.irq_status = next_status;
      next_r.irq = |(next_r.irq_status & next_r.irq_mask);
      // Power-saving mode asserts read enable only on demand
      // Never while the array programs or erases
      next_r.read_en = !next_r.erase && !next_r.prog &&
                       (next_r.cont_read || i_array_read_req);
   end

   // State freezes while the clock enable is low
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         r <= '0;
         r.timing <= fwec_pkg::RST_TIMING;
         r.state <= fwec_pkg::FWEC_IDLE;
      end
      else if (i_ce)
         r <= next_r;
   end

   // ==========================================
   // Outputs
   // Read port
   assign o_rdata = r.rdata;
   // Array controls, all registered
   assign o_array_prog = r.prog;
   assign o_array_erase = r.erase;
   assign o_array_addr = {r.addr_high, r.addr_low};
   assign o_array_wdata = r.data;
   assign o_array_read_en = r.read_en;
   // Events
   assign o_dma_trigger = r.dma;
   assign o_irq = r.irq;
endmodule : fwec_top

// [tb/fwec_flash_model.sv]
`timescale 1ns/100ps
// ==========================================
// Flash array: bytes erase to ones, programming only clears bits
module fwec_flash_model
(
   // Clock
   input wire logic i_clk,
   // Array controls
   input wire logic i_prog,
   input wire logic i_erase,
   input wire logic [14:0] i_addr,
   input wire logic [7:0] i_wdata
);
   logic [7:0] mem [0:32767];
   logic prog_q = 1'b0;
   // Start blank at zero so that an erase shows up
   initial
   begin
      for (int k = 0; k < 32768; k++)
         mem[k] = 8'h00;
   end
   // Program lands as the pulse ends; no bit can go back to one
   always @(posedge i_clk)
   begin
      prog_q <= i_prog;
      if (i_erase)
         for (int k = 0; k < 512; k++)
            mem[{i_addr[14:9], k[8:0]}] <= 8'hff;
      if (prog_q && !i_prog)
         mem[i_addr] <= mem[i_addr] & i_wdata;
   end
endmodule : fwec_flash_model

// [tb/fwec_asserts.sv]
`timescale 1ns/100ps
// ==========================================
// Port checker of the sequencer
module fwec_asserts
#(
   parameter int ERASE_CYCLES = fwec_pkg::ERASE_CYCLES
)
(
   // Clock and register port
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [7:0] i_addr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Array side and events
   input wire logic o_array_prog,
   input wire logic o_array_erase,
   input wire logic o_array_read_en,
   input wire logic o_dma_trigger,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   localparam int ER_LO = ERASE_CYCLES - 1;
   localparam int ER_HI = ERASE_CYCLES + 3;
   logic [31:0] er_cnt;
   logic rd_ctl;
   logic act;
   // Erase length counted here; a repetition that long would not unroll
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         er_cnt <= '0;
      else
         er_cnt <= o_array_erase ? er_cnt + 32'h0000_0001 : '0;
   end
   // Control read and array activity
   assign rd_ctl = i_rd && i_ce && (i_addr == fwec_pkg::ADDR_PROGRAM_CONTROL);
   assign act = o_array_prog || o_array_erase;
   AST_BUSY_READ: assert property (rd_ctl && act |=> o_rdata[7])
      else $error("busy flag low while the array works");
   AST_CMD_RD0: assert property (rd_ctl |=> o_rdata[1:0] == 2'b00)
      else $error("command bits read back nonzero");
   AST_ONE_PHASE: assert property (!(o_array_prog && o_array_erase))
      else $error("erase and program overlap");
   AST_DMA_END: assert property (o_dma_trigger |-> $past(o_array_prog) && !o_array_prog)
      else $error("dma trigger not at end of program");
   AST_DMA_ONE: assert property (o_dma_trigger |=> !o_dma_trigger)
      else $error("dma trigger longer than one cycle");
   AST_ERASE_LEN: assert property ($fell(o_array_erase) |-> er_cnt >= ER_LO && er_cnt <= ER_HI)
      else $error("erase length wrong");
   AST_RDEN_IDLE: assert property (act |-> !o_array_read_en)
      else $error("read enable during program or erase");
   AST_RDATA_IDLE: assert property (!$past(i_rd && i_ce) |-> o_rdata == 8'h00)
      else $error("read data outside read cycle");
   CV_ERASE: cover property ($fell(o_array_erase));
   CV_DMA: cover property (o_dma_trigger);
   CV_RDEN: cover property (o_array_read_en);
   CV_IRQ: cover property (o_irq);
endmodule : fwec_asserts
bind fwec_top fwec_asserts #(.ERASE_CYCLES(ERASE_CYCLES)) u_asserts (.i_clk(i_clk),
   .i_rst(i_rst), .i_ce(i_ce), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_array_prog(o_array_prog), .o_array_erase(o_array_erase),
   .o_array_read_en(o_array_read_en), .o_dma_trigger(o_dma_trigger), .o_irq(o_irq));

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   localparam logic [7:0] A_TIM = fwec_pkg::ADDR_PROGRAM_TIMING;
   localparam logic [7:0] A_LOW = fwec_pkg::ADDR_WORD_ADDRESS_LOW;
   localparam logic [7:0] A_HIGH = fwec_pkg::ADDR_WORD_ADDRESS_HIGH;
   localparam logic [7:0] A_CTL = fwec_pkg::ADDR_PROGRAM_CONTROL;
   localparam logic [7:0] A_DAT = fwec_pkg::ADDR_PROGRAM_DATA;
   localparam logic [7:0] A_STS = fwec_pkg::ADDR_IRQ_STATUS;
   localparam logic [7:0] A_MSK = fwec_pkg::ADDR_IRQ_MASK;
   logic i_clk, i_rst, i_ce, i_wr, i_rd, rreq, prog, erase, rden, dma, irq;
   logic [7:0] i_addr, i_wdata, rdata, awdata;
   logic [14:0] aaddr;
   int failures = 0;
   int n_checks = 0;
   int dma_cnt = 0;
   // ==========================================
   // Design, array model, clock
   fwec_top #(.ERASE_CYCLES(50)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
      .o_array_prog(prog), .o_array_erase(erase), .o_array_addr(aaddr),
      .o_array_wdata(awdata), .o_array_read_en(rden), .i_array_read_req(rreq),
      .o_dma_trigger(dma), .o_irq(irq));
   fwec_flash_model u_flash (.i_clk(i_clk), .i_prog(prog), .i_erase(erase),
      .i_addr(aaddr), .i_wdata(awdata));
   initial
   begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // Count trigger pulses, one per committed word
   always @(posedge i_clk)
      if (dma === 1'b1)
         dma_cnt <= dma_cnt + 1;
   // ==========================================
   // Bus tasks and checks
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_of_test;
      if (failures == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = rdata;
   endtask : rd
   task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      check(name, v, exp);
   endtask : rdc
   // Poll the busy flag under a bound
   task automatic wait_idle;
      logic [7:0] v;
      v = 8'h80;
      for (int n = 0; n < 200 && v[7] !== 1'b0; n++)
         rd(A_CTL, v);
      if (v[7] !== 1'b0)
      begin
         failures++;
         end_of_test();
      end
   endtask : wait_idle
   task automatic req_check(input logic r, input logic e);
      @(posedge i_clk);
      rreq <= r;
      repeat (3) @(posedge i_clk);
      #1 check("read enable", rden, e);
   endtask : req_check
   // ==========================================
   // Main sequence
   initial
   begin
      {i_rst, i_ce, i_wr, i_rd, rreq, i_addr, i_wdata} = {2'b11, 3'b000, 16'h0000};
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      rdc("timing", A_TIM, 8'h2a);
      rdc("addr low", A_LOW, 8'h00);
      rdc("addr high", A_HIGH, 8'h00);
      rdc("control", A_CTL, 8'h00);
      rdc("data", A_DAT, 8'h00);
      wr(A_LOW, 8'ha5);
      wr(A_HIGH, 8'h83);
      wr(A_TIM, 8'h02);
      wr(8'h00, 8'hff);
      rdc("addr low", A_LOW, 8'ha5);
      rdc("addr high", A_HIGH, 8'h83);
      rdc("timing", A_TIM, 8'h02);
      rdc("unmapped", 8'h00, 8'h00);
      wr(A_CTL, 8'h3c);
      rdc("control spare", A_CTL, 8'h3c);
      check("read enable", rden, 1'b1);
      wr(A_CTL, 8'h00);
      req_check(1'b0, 1'b0);
      req_check(1'b1, 1'b1);
      req_check(1'b0, 1'b0);
      // Erase then write in one command
      wr(A_MSK, 8'h03);
      wr(A_DAT, 8'h3c);
      wr(A_CTL, 8'h03);
      rdc("control busy", A_CTL, 8'hc0);
      check("erase first", {prog, erase}, 2'b01);
      check("array addr", aaddr, 15'h03a5);
      check("array data", awdata, 8'h3c);
      wait_idle();
      check("word", u_flash.mem[15'h03a5], 8'h3c);
      check("page", u_flash.mem[15'h0200], 8'hff);
      check("other page", u_flash.mem[15'h0400], 8'h00);
      check("dma", 16'(dma_cnt), 16'h0001);
      check("irq", irq, 1'b1);
      rdc("status", A_STS, 8'h03);
      wr(A_STS, 8'h03);
      rdc("status", A_STS, 8'h00);
      check("irq", irq, 1'b0);
      // Plain write; an erase command while busy is dropped
      wr(A_TIM, 8'h2a);
      wr(A_MSK, 8'h02);
      wr(A_DAT, 8'h0f);
      wr(A_CTL, 8'h02);
      wr(A_CTL, 8'h01);
      @(posedge i_clk);
      #1 check("no erase", erase, 1'b0);
      wait_idle();
      rdc("control idle", A_CTL, 8'h00);
      check("no erase", erase, 1'b0);
      check("word", u_flash.mem[15'h03a5], 8'h0c);
      check("dma", 16'(dma_cnt), 16'h0002);
      rdc("status", A_STS, 8'h01);
      check("irq masked", irq, 1'b0);
      // A write while the clock enable is low must not land
      @(posedge i_clk);
      i_ce <= 1'b0;
      wr(A_LOW, 8'h5a);
      i_ce <= 1'b1;
      rdc("frozen", A_LOW, 8'ha5);
      end_of_test();
   end
endmodule : tb_top
